// ---- rtl/rba_bank.sv ----
// register bank that implements the per-bit access attributes of the switch
//
// Overview of operation
// R1: read-only bits return live value; writes are ignored.
// R2: read-to-clear bits return contents, clear after the read, ignore writes.
// R3: write-only bits accept writes; read data is unspecified, here zero.
// R4: write-one-to-clear bits clear where one is written; zero leaves them.
// R5: latch-low bits hold low until read, then follow the condition.
// R6: latch-high bits hold high until read, then follow the condition.
// R7: self-clearing bits fall to zero by themselves; zero writes ignored; readable.
// R8: host writes zeros to reserved fields and ignores their read value.
// R9: every register is reachable from management serial port and in-band port.
// R10: a set event in the clearing cycle keeps the bit set.
// R11: reset gives every bit its default; latched and self-clearing bits cleared.
//
// register map, one 16-bit word per index:
//   0 read-only live status, sampled every clock, so one cycle late
//   1 read-to-clear event capture
//   2 write-only control word, shown on o_wronly_ctrl
//   3 write-one-to-clear event capture
//   4 latch-low status, combined with the live condition
//   5 latch-high status, combined with the live condition
//   6 self-clearing command pulses, one cycle wide
//   7 reserved: reads zero, writes are dropped
//
// all paths share one read data register; only the winner sees ack,
// so a path must take its data in its own ack cycle or soon after
`timescale 1ns/1ps
module rba_bank
    import rba_pkg::*;
(
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst,
    // access paths: spi, i2c, in-band
    input wire rba_req_t i_req [RBA_NPATH],
    output rba_rsp_t o_rsp [RBA_NPATH],
    // hardware status inputs
    input wire logic [RBA_DW-1:0] i_rdonly_status,
    input wire logic [RBA_DW-1:0] i_rdclr_event,
    input wire logic [RBA_DW-1:0] i_w1clr_event,
    input wire logic [RBA_DW-1:0] i_latlo_cond,
    input wire logic [RBA_DW-1:0] i_lathi_cond,
    // control outputs to the block logic
    output logic [RBA_DW-1:0] o_wronly_ctrl,
    output logic [RBA_DW-1:0] o_selfclr_pulse
);
    // ==========================================================
    // state
    // ==========================================================
    typedef struct packed {
        // arbiter phase and last winning path
        rba_arb_t arb;
        logic [1:0] last;
        // live status copy
        logic [RBA_DW-1:0] rdonly;
        // captured events, cleared by read
        logic [RBA_DW-1:0] rdclr;
        // control word written by the host
        logic [RBA_DW-1:0] wronly;
        // captured events, cleared by writing ones
        logic [RBA_DW-1:0] w1clr;
        // command pulses, zero again one cycle later
        logic [RBA_DW-1:0] selfclr;
        // answer to the paths
        logic [RBA_NPATH-1:0] ack;
        logic [RBA_DW-1:0] rdata;
    } rba_st_t;

    rba_st_t st_q;
    rba_st_t st_d;
    logic [RBA_DW-1:0] latlo_val;
    logic [RBA_DW-1:0] lathi_val;
    logic latlo_clr;
    logic lathi_clr;
    logic [1:0] grant;
    logic grant_ok;
    rba_req_t cur;
    logic [RBA_DW-1:0] rd_mux;

    // ==========================================================
    // latching status fields
    // ==========================================================
    // both latch kinds share one module so set-beats-clear is written once
    rba_latch_bit #(.LATCH_HIGH(1'b0)) u_latlo (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_cond(i_latlo_cond),
        .i_rd_clr(latlo_clr),
        .o_val(latlo_val)
    );

    rba_latch_bit #(.LATCH_HIGH(1'b1)) u_lathi (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_cond(i_lathi_cond),
        .i_rd_clr(lathi_clr),
        .o_val(lathi_val)
    );

    // ==========================================================
    // arbitration among paths
    // ==========================================================
    // round robin after the last winner so no path starves the others
    always_comb begin
        logic [1:0] idx;
        idx = '0;
        grant = st_q.last;
        grant_ok = 1'b0;
        for (int k = 1; k <= RBA_NPATH; k++) begin
            idx = 2'((int'(st_q.last) + k) % RBA_NPATH);
            if (!grant_ok && (i_req[idx].rd || i_req[idx].wr)) begin
                grant = idx; // [R9]
                grant_ok = 1'b1;
            end
        end
    end

    // one access per two cycles: the busy cycle lets the requester drop its strobe
    assign cur = i_req[grant];
    // the latch is cleared only by the read that is actually taken
    assign latlo_clr = (st_q.arb == RBA_ARB_IDLE) && grant_ok && cur.rd
        && cur.addr == RBA_IDX_LATLO; // [R5]
    assign lathi_clr = (st_q.arb == RBA_ARB_IDLE) && grant_ok && cur.rd
        && cur.addr == RBA_IDX_LATHI; // [R6]

    // ==========================================================
    // read data selection
    // ==========================================================
    // write-only words read zero so no control value leaks to another path
    always_comb begin
        unique case (cur.addr)
            RBA_IDX_RDONLY: rd_mux = st_q.rdonly; // [R1]
            RBA_IDX_RDCLR: rd_mux = st_q.rdclr; // [R2]
            RBA_IDX_WRONLY: rd_mux = RBA_RST_ZERO; // [R3]
            RBA_IDX_W1CLR: rd_mux = st_q.w1clr; // [R4]
            RBA_IDX_LATLO: rd_mux = latlo_val; // [R5]
            RBA_IDX_LATHI: rd_mux = lathi_val; // [R6]
            RBA_IDX_SELFCLR: rd_mux = st_q.selfclr; // [R7]
            RBA_IDX_RSV: rd_mux = RBA_RST_ZERO; // reserved reads zero
        endcase
    end

    // ==========================================================
    // next state
    // ==========================================================
    always_comb begin
        st_d = st_q;
        st_d.ack = '0;
        st_d.rdonly = i_rdonly_status; // [R1]
        st_d.selfclr = RBA_RST_ZERO; // [R7]
        st_d.rdclr = st_q.rdclr | i_rdclr_event; // [R2]
        st_d.w1clr = st_q.w1clr | i_w1clr_event; // [R4]
        unique case (st_q.arb)
            RBA_ARB_IDLE: begin
                if (grant_ok) begin
                    st_d.arb = RBA_ARB_BUSY;
                    st_d.last = grant;
                    st_d.ack[grant] = 1'b1; // [R9]
                    if (cur.rd) begin
                        st_d.rdata = rd_mux;
                        if (cur.addr == RBA_IDX_RDCLR) begin
                            st_d.rdclr = i_rdclr_event; // [R2] [R10]
                        end
                    end else begin
                        st_d.rdata = RBA_RST_ZERO;
                        // a fresh event wins over the clearing write
                        unique case (cur.addr)
                            RBA_IDX_WRONLY: st_d.wronly = cur.wdata; // [R3]
                            RBA_IDX_W1CLR: st_d.w1clr = (st_q.w1clr & ~cur.wdata)
                                | i_w1clr_event; // [R4]
                            RBA_IDX_SELFCLR: st_d.selfclr = cur.wdata; // [R7]
                            default: st_d.wronly = st_q.wronly; // writes ignored [R1]
                        endcase
                    end
                end
            end
            RBA_ARB_BUSY: begin
                st_d.arb = RBA_ARB_IDLE;
            end
            default: begin
                st_d.arb = RBA_ARB_IDLE;
            end
        endcase
    end

    // ==========================================================
    // registers
    // ==========================================================
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            st_q.arb <= RBA_ARB_IDLE; // [R11]
            st_q.last <= RBA_PATH_INB;
            st_q.rdonly <= RBA_RST_ZERO;
            st_q.rdclr <= RBA_RST_ZERO;
            st_q.wronly <= RBA_RST_ZERO;
            st_q.w1clr <= RBA_RST_ZERO;
            st_q.selfclr <= RBA_RST_ZERO;
            st_q.ack <= '0;
            st_q.rdata <= RBA_RST_ZERO;
        end else begin
            st_q <= st_d;
        end
    end

    // outputs straight from flip-flops
    assign o_wronly_ctrl = st_q.wronly;
    assign o_selfclr_pulse = st_q.selfclr;
    for (genvar p = 0; p < RBA_NPATH; p++) begin : g_rsp
        assign o_rsp[p].ack = st_q.ack[p];
        assign o_rsp[p].rdata = st_q.rdata;
    end
endmodule

// ---- rtl/rba_latch_bit.sv ----
// one latching status field, latch low or latch high selected by parameter
`timescale 1ns/1ps
module rba_latch_bit
    import rba_pkg::*;
#(
    parameter bit LATCH_HIGH = 1'b1
) (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst,
    // live condition and clearing read
    input wire logic [RBA_DW-1:0] i_cond,
    input wire logic i_rd_clr,
    // visible value
    output logic [RBA_DW-1:0] o_val
);
    // state: latched event bits, one where an event has been caught
    typedef struct packed {
        logic [RBA_DW-1:0] held;
    } rba_lb_st_t;

    rba_lb_st_t st_q;
    rba_lb_st_t st_d;
    logic [RBA_DW-1:0] ev;

    // an event is the condition reaching the latching level
    assign ev = LATCH_HIGH ? i_cond : ~i_cond;

    // a read clears the latch, but an event in the same cycle keeps it
    always_comb begin
        st_d = st_q;
        if (i_rd_clr) begin
            st_d.held = ev; // [R10]
        end else begin
            st_d.held = st_q.held | ev; // [R5] [R6]
        end
    end

    // latched bits start cleared so the field follows the condition
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            st_q <= '0; // [R11]
        end else begin
            st_q <= st_d;
        end
    end

    // visible value is the held level or the live condition
    assign o_val = LATCH_HIGH ? (st_q.held | i_cond) : (~st_q.held & i_cond);
endmodule

// ---- rtl/rba_pkg.sv ----
// package for the register bit attribute bank: widths, resets, bit map, access types
package rba_pkg;
    // register data width of one management word
    localparam int RBA_DW = 16;
    // number of access paths that may reach the bank
    localparam int RBA_NPATH = 3;
    // address width of the bank
    localparam int RBA_AW = 3;
    // register index of each attribute register
    localparam logic [RBA_AW-1:0] RBA_IDX_RDONLY = 3'h0;
    localparam logic [RBA_AW-1:0] RBA_IDX_RDCLR = 3'h1;
    localparam logic [RBA_AW-1:0] RBA_IDX_WRONLY = 3'h2;
    localparam logic [RBA_AW-1:0] RBA_IDX_W1CLR = 3'h3;
    localparam logic [RBA_AW-1:0] RBA_IDX_LATLO = 3'h4;
    localparam logic [RBA_AW-1:0] RBA_IDX_LATHI = 3'h5;
    localparam logic [RBA_AW-1:0] RBA_IDX_SELFCLR = 3'h6;
    localparam logic [RBA_AW-1:0] RBA_IDX_RSV = 3'h7;
    // reset values
    localparam logic [RBA_DW-1:0] RBA_RST_ZERO = 16'h0000;
    localparam logic [RBA_DW-1:0] RBA_RST_ONES = 16'hFFFF;
    // path numbers
    localparam logic [1:0] RBA_PATH_SPI = 2'h0;
    localparam logic [1:0] RBA_PATH_I2C = 2'h1;
    localparam logic [1:0] RBA_PATH_INB = 2'h2;

    // one management access request from a path
    typedef struct packed {
        logic rd;
        logic wr;
        logic [RBA_AW-1:0] addr;
        logic [RBA_DW-1:0] wdata;
    } rba_req_t;

    // answer to an access
    typedef struct packed {
        logic ack;
        logic [RBA_DW-1:0] rdata;
    } rba_rsp_t;

    // arbiter state
    typedef enum logic [1:0] {
        RBA_ARB_IDLE = 2'b00,
        RBA_ARB_BUSY = 2'b01
    } rba_arb_t;
endpackage

// ---- sim/rba_bank_assertions.sv ----
// checker on the ports of the register bit attribute bank
`timescale 1ns/1ps
module rba_bank_assertions
    import rba_pkg::*;
(
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst,
    // access paths
    input wire rba_req_t i_req [RBA_NPATH],
    input wire rba_rsp_t o_rsp [RBA_NPATH],
    // status and control
    input wire logic [RBA_DW-1:0] i_rdonly_status,
    input wire logic [RBA_DW-1:0] o_wronly_ctrl,
    input wire logic [RBA_DW-1:0] o_selfclr_pulse
);
    logic [2:0] ak;
    rba_req_t w;
    logic wr_ctl;
    logic wr_pls;
    // ========================================
    // winner decode: its request is still held in the ack cycle
    assign ak = {o_rsp[2].ack, o_rsp[1].ack, o_rsp[0].ack};
    assign w = ak[2] ? i_req[2] : (ak[1] ? i_req[1] : i_req[0]);
    assign wr_ctl = (ak != 3'h0) && w.wr && !w.rd && (w.addr == RBA_IDX_WRONLY);
    assign wr_pls = (ak != 3'h0) && w.wr && !w.rd && (w.addr == RBA_IDX_SELFCLR);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);
    // ========================================
    // properties
    a_ack_onehot: assert property ($onehot0(ak))
        else $error("two paths answered at once");
    a_ack_spacing: assert property (ak != 3'h0 |=> ak == 3'h0)
        else $error("answers closer than two cycles");
    a_status_read_late: assert property (ak != 3'h0 && w.rd && w.addr == RBA_IDX_RDONLY
        |-> o_rsp[0].rdata == $past(i_rdonly_status, 2)) else $error("read-only value wrong");
    a_ctl_write: assert property (wr_ctl |-> o_wronly_ctrl == w.wdata)
        else $error("write-only value not taken");
    a_ctl_hold: assert property ($changed(o_wronly_ctrl) |-> wr_ctl)
        else $error("write-only value moved without write");
    a_write_rdata_zero: assert property (ak != 3'h0 && w.wr && !w.rd
        |-> o_rsp[0].rdata == 16'h0000) else $error("write answer not zero");
    a_pulse_value: assert property (wr_pls |-> o_selfclr_pulse == w.wdata)
        else $error("self-clearing pulse wrong");
    a_pulse_cause: assert property (o_selfclr_pulse != 16'h0000 |-> wr_pls)
        else $error("self-clearing pulse without write");
    a_pulse_clear: assert property (o_selfclr_pulse != 16'h0000 |=> o_selfclr_pulse == 16'h0000)
        else $error("self-clearing bit stuck");
    a_rdata_stands: assert property (ak == 3'h0 |-> $stable(o_rsp[0].rdata))
        else $error("read data moved without answer");
    c_path0: cover property (ak[0]);
    c_path2: cover property (ak[2]);
    c_pulse: cover property (o_selfclr_pulse != 16'h0000);
endmodule

// ---- sim/rba_host.sv ----
// host model that issues register accesses on one management path
`timescale 1ns/1ps
module rba_host
    import rba_pkg::*;
(
    // clock
    input wire logic i_ref_clk,
    // answer from and request to the bank
    input wire rba_rsp_t i_rsp,
    output rba_req_t o_req
);
    // idle from time zero so nothing is asked during reset
    initial begin
        o_req = '0;
    end
    // ========================================
    // one access: hold until ack is sampled high and for one more cycle, then let go
    task automatic acc(input logic rd, input logic [RBA_AW-1:0] a,
                       input logic [RBA_DW-1:0] d, output logic [RBA_DW-1:0] q);
        @(posedge i_ref_clk);
        #1;
        o_req = '{rd, !rd, a, rd ? 16'h0000 : d};
        do begin
            @(posedge i_ref_clk);
            #1;
        end while (i_rsp.ack !== 1'b1);
        q = i_rsp.rdata;
        @(posedge i_ref_clk);
        #1;
        // released lines show inverted data so stale values cannot pass
        o_req = '{1'b0, 1'b0, ~a, ~d};
    endtask
endmodule

// ---- sim/test_rba_bank.sv ----
// self-checking testbench for the register bit attribute bank
`timescale 1ns/1ps
module test_rba_bank
    import rba_pkg::*;
();
    typedef struct packed {
        logic rd;
        logic [RBA_AW-1:0] a;
        logic [RBA_DW-1:0] d;
        logic [RBA_DW-1:0] e;
    } rba_row_t;
    logic i_ref_clk = 1'b0;
    logic i_rst = 1'b1;
    rba_req_t req [RBA_NPATH];
    rba_rsp_t rsp [RBA_NPATH];
    logic [RBA_DW-1:0] st_in = 16'h0000, clr_ev = 16'h0000, w1_ev = 16'h0000;
    logic [RBA_DW-1:0] lo_cd = 16'hFFFF, hi_cd = 16'h0000, ctl_out, pls_out, q, qa, qb, qc;
    logic [RBA_DW-1:0] pls_seen = 16'h0000;
    int bad_count = 0, n_checks = 0, cyc = 0;
    // writes answer with zero read data
    rba_row_t rows [14] = '{
        '{1'b0, 3'h0, 16'hFFFF, 16'h0000}, '{1'b1, 3'h0, 16'h0000, 16'h1234},
        '{1'b0, 3'h1, 16'hFFFF, 16'h0000}, '{1'b1, 3'h1, 16'h0000, 16'h00A5},
        '{1'b1, 3'h1, 16'h0000, 16'h0000}, '{1'b0, 3'h2, 16'h3C5A, 16'h0000},
        '{1'b0, 3'h3, 16'h0003, 16'h0000}, '{1'b1, 3'h3, 16'h0000, 16'h0F0C},
        '{1'b1, 3'h4, 16'h0000, 16'hFFF7}, '{1'b1, 3'h4, 16'h0000, 16'hFFFF},
        '{1'b1, 3'h5, 16'h0000, 16'h0010}, '{1'b1, 3'h5, 16'h0000, 16'h0000},
        '{1'b0, 3'h6, 16'h0005, 16'h0000}, '{1'b1, 3'h6, 16'h0000, 16'h0000}};

    rba_bank rba_bank_i (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_req(req), .o_rsp(rsp),
        .i_rdonly_status(st_in), .i_rdclr_event(clr_ev), .i_w1clr_event(w1_ev),
        .i_latlo_cond(lo_cd), .i_lathi_cond(hi_cd), .o_wronly_ctrl(ctl_out),
        .o_selfclr_pulse(pls_out));
    rba_host host0 (.i_ref_clk(i_ref_clk), .i_rsp(rsp[0]), .o_req(req[0]));
    rba_host host1 (.i_ref_clk(i_ref_clk), .i_rsp(rsp[1]), .o_req(req[1]));
    rba_host host2 (.i_ref_clk(i_ref_clk), .i_rsp(rsp[2]), .o_req(req[2]));

    // ========================================
    // clock, hang guard and helpers
    always #20 i_ref_clk = ~i_ref_clk;
    // the pulse stands one cycle only, so catch it where it stands
    always @(posedge i_ref_clk) begin
        if (pls_out != 16'h0000) begin
            pls_seen <= pls_out;
        end
    end
    always @(posedge i_ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            bad_count++;
            finish_test();
        end
    end
    task automatic finish_test();
        if (bad_count == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [RBA_DW-1:0] got, input logic [RBA_DW-1:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic go(input int p, input logic rd, input logic [RBA_AW-1:0] a,
                      input logic [RBA_DW-1:0] d, output logic [RBA_DW-1:0] r);
        case (p)
            0: host0.acc(rd, a, d, r);
            1: host1.acc(rd, a, d, r);
            default: host2.acc(rd, a, d, r);
        endcase
    endtask

    // ========================================
    // main sequence
    initial begin
        repeat (20) @(posedge i_ref_clk);
        #1;
        i_rst = 1'b0;
        chk(ctl_out, 16'h0000);
        chk(rsp[0].rdata, 16'h0000);
        // one cycle of events and glitches that must be kept
        st_in = 16'h1234;
        clr_ev = 16'h00A5;
        w1_ev = 16'h0F0F;
        lo_cd = 16'hFFF7;
        hi_cd = 16'h0010;
        @(posedge i_ref_clk);
        #1;
        clr_ev = 16'h0000;
        w1_ev = 16'h0000;
        lo_cd = 16'hFFFF;
        hi_cd = 16'h0000;
        // paths rotate so every row also exercises a different port
        for (int i = 0; i < 14; i++) begin
            go(i % 3, rows[i].rd, rows[i].a, rows[i].d, q);
            chk(q, rows[i].e);
        end
        chk(ctl_out, 16'h3C5A);
        chk(pls_seen, 16'h0005);
        chk(pls_out, 16'h0000);
        // event still present during the clearing read
        clr_ev = 16'h0002;
        go(0, 1'b1, RBA_IDX_RDCLR, 16'h0000, q);
        chk(q, 16'h0002);
        clr_ev = 16'h0000;
        go(1, 1'b1, RBA_IDX_RDCLR, 16'h0000, q);
        chk(q, 16'h0002);
        go(2, 1'b1, RBA_IDX_RDCLR, 16'h0000, q);
        chk(q, 16'h0000);
        // latch-high condition still present during its clearing read
        hi_cd = 16'h0020;
        go(0, 1'b1, RBA_IDX_LATHI, 16'h0000, q);
        chk(q, 16'h0020);
        hi_cd = 16'h0000;
        go(1, 1'b1, RBA_IDX_LATHI, 16'h0000, q);
        chk(q, 16'h0020);
        go(2, 1'b1, RBA_IDX_LATHI, 16'h0000, q);
        chk(q, 16'h0000);
        // all three paths asking in the same cycle
        fork
            go(0, 1'b1, RBA_IDX_RDONLY, 16'h0000, qa);
            go(1, 1'b0, RBA_IDX_WRONLY, 16'h00FF, qb);
            go(2, 1'b1, RBA_IDX_RDONLY, 16'h0000, qc);
        join
        chk(qa, 16'h1234);
        chk(qb, 16'h0000);
        chk(qc, 16'h1234);
        chk(ctl_out, 16'h00FF);
        // reserved word written with zeros leaves the write-only control word alone
        go(1, 1'b0, RBA_IDX_RSV, 16'h0000, q);
        chk(ctl_out, 16'h00FF);
        // second reset with a latched high pending
        hi_cd = 16'h0040;
        @(posedge i_ref_clk);
        #1;
        hi_cd = 16'h0000;
        i_rst = 1'b1;
        @(posedge i_ref_clk);
        #1;
        i_rst = 1'b0;
        chk(ctl_out, 16'h0000);
        go(0, 1'b1, RBA_IDX_LATHI, 16'h0000, q);
        chk(q, 16'h0000);
        finish_test();
    end
endmodule

bind rba_bank rba_bank_assertions rba_bank_assertions_i (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
    .i_req(i_req), .o_rsp(o_rsp), .i_rdonly_status(i_rdonly_status),
    .o_wronly_ctrl(o_wronly_ctrl), .o_selfclr_pulse(o_selfclr_pulse));
